/* File: hmi_params.svh */
`ifndef HMI_PARAMS_SVH
`define HMI_PARAMS_SVH
// ==========================================
// bus widths and fixed map constants
`define HMI_PROG_AW      22
`define HMI_DAB_W        32
`define HMI_DATA_W       32
`define HMI_WORD_W       16
`define HMI_VEC_BASE     22'h3FFFC0
`define HMI_VEC_WORDS    7'h40
`define HMI_VEC_COUNT    6'h20
`define HMI_MEM_DEPTH_LOG 10
`endif

/* File: hmi_pkg.sv */
package hmi_pkg;
    // access size carried beside every data read and write, and program writes
    typedef enum logic [1:0] {
        HMI_SZ_16  = 2'h0,
        HMI_SZ_32  = 2'h1,
        HMI_SZ_LO8 = 2'h2,
        HMI_SZ_HI8 = 2'h3
    } hmi_size_t;
    // requester state: one-hot
    typedef enum logic [2:0] {
        HMI_ST_IDLE = 3'b001,
        HMI_ST_RUN  = 3'b010,
        HMI_ST_HOLD = 3'b100
    } hmi_state_t;
endpackage

/* File: hmi_bus_if.sv */
`timescale 1ns/1ps
`include "hmi_params.svh"
interface hmi_bus_if;
    // program side
    logic [`HMI_PROG_AW-1:0] prog_addr_bus;
    logic                   prog_rd;
    logic                   prog_wr;
    logic [`HMI_DATA_W-1:0] prog_rd_data_bus;
    // data side
    logic [`HMI_DAB_W-1:0]  data_rd_addr_bus;
    logic                   data_rd;
    hmi_pkg::hmi_size_t     data_rd_size;
    logic [`HMI_DAB_W-1:0]  data_wr_addr_bus;
    logic                   data_wr;
    hmi_pkg::hmi_size_t     data_wr_size;
    logic [`HMI_DATA_W-1:0] data_rd_data_bus;
    logic [`HMI_DATA_W-1:0] shared_wr_data_bus;
    // byte strobes, read and write
    logic                   rd_low_byte_lane;
    logic                   rd_high_byte_lane;
    logic                   wr_low_byte_lane;
    logic                   wr_high_byte_lane;
    modport cpu (
        output prog_addr_bus, prog_rd, prog_wr, data_rd_addr_bus, data_rd, data_rd_size,
        output data_wr_addr_bus, data_wr, data_wr_size, shared_wr_data_bus,
        output rd_low_byte_lane, rd_high_byte_lane, wr_low_byte_lane, wr_high_byte_lane,
        input  prog_rd_data_bus, data_rd_data_bus
    );
    modport mem (
        input  prog_addr_bus, prog_rd, prog_wr, data_rd_addr_bus, data_rd, data_rd_size,
        input  data_wr_addr_bus, data_wr, data_wr_size, shared_wr_data_bus,
        input  rd_low_byte_lane, rd_high_byte_lane, wr_low_byte_lane, wr_high_byte_lane,
        output prog_rd_data_bus, data_rd_data_bus
    );
endinterface

/* File: hmi_word_ram.sv */
`timescale 1ns/1ps
`include "hmi_params.svh"
module hmi_word_ram #(
    parameter int AW = `HMI_MEM_DEPTH_LOG
) (
    // clock
    input  wire logic        clk,
    // read port
    input  wire logic [AW-1:0] ra,
    output logic      [31:0]   rd,
    // write port, one enable per 16-bit word half
    input  wire logic [AW-1:0] wa,
    input  wire logic [1:0]    we,
    input  wire logic [31:0]   wd
);
    logic [15:0] mem [0:(1<<AW)-1];
    // 32-bit read: low word at even address, high word at next
    always_ff @(posedge clk) begin
        rd <= {mem[ra | AW'(1)], mem[ra & ~AW'(1)]};
    end
    // word writes; no reset on array contents
    always_ff @(posedge clk) begin
        if (we[0]) begin
            mem[wa] <= wd[15:0];
        end
        if (we[1]) begin
            mem[wa | AW'(1)] <= wd[31:16];
        end
    end
endmodule

/* File: hmi_mem_end.sv */
`timescale 1ns/1ps
`include "hmi_params.svh"
module hmi_mem_end #(
    parameter int AW = `HMI_MEM_DEPTH_LOG
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // cpu link
    hmi_bus_if.mem    bus
);
    logic [AW-1:0] pa;
    logic [AW-1:0] ra;
    logic [AW-1:0] wa;
    logic [AW-1:0] pwa;
    logic [AW-1:0] a_even;
    logic [1:0]    we;
    logic [31:0]   wd;
    logic [31:0]   prd;
    logic [31:0]   drd;
    logic [1:0]    rsz;
    logic          rhi;
    // one decode for both spaces, low address bits select the word
    assign pa = bus.prog_addr_bus[AW-1:0];
    assign ra = bus.data_rd_addr_bus[AW-1:0];
    // a program write takes the program address; cpu never overlaps it with a data write
    assign pwa    = bus.prog_wr ? pa : bus.data_wr_addr_bus[AW-1:0];
    assign a_even = pwa & ~AW'(1);
    // write lanes: 32-bit forced even, 16-bit at its own address
    always_comb begin
        we = 2'h0;
        wa = pwa;
        wd = bus.shared_wr_data_bus;
        if (bus.prog_wr) begin
            wa = a_even;
            we = 2'h3;
        end else if (bus.data_wr) begin
            case (bus.data_wr_size)
                hmi_pkg::HMI_SZ_32: begin
                    wa = a_even;
                    we = 2'h3;
                end
                default: begin
                    wa = pwa;
                    we = 2'h1;
                end
            endcase
        end
    end
    // byte writes are not merged: the whole 16-bit word is written, lane strobes ignored
    hmi_word_ram #(.AW(AW)) u_prog (
        .clk (clk),
        .ra  (pa),
        .rd  (prd),
        .wa  (wa),
        .we  (we),
        .wd  (wd)
    );
    hmi_word_ram #(.AW(AW)) u_data (
        .clk (clk),
        .ra  (ra),
        .rd  (drd),
        .wa  (wa),
        .we  (we),
        .wd  (wd)
    );
    // remember read shape for the answer cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rsz <= 2'h0;
            rhi <= 1'b0;
        end else begin
            rsz <= bus.data_rd_size;
            rhi <= bus.data_rd_addr_bus[0];
        end
    end
    // answers one cycle after the request
    assign bus.prog_rd_data_bus = prd;
    always_comb begin
        case (rsz)
            2'h1:    bus.data_rd_data_bus = drd;
            default: bus.data_rd_data_bus = {16'h0000, rhi ? drd[31:16] : drd[15:0]};
        endcase
    end
endmodule

/* File: hmi_cpu_end.sv */
`timescale 1ns/1ps
`include "hmi_params.svh"
module hmi_cpu_end (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    // fetch requests
    input  wire logic                   fetch_req,
    input  wire logic [`HMI_PROG_AW-1:0] fetch_addr,
    output logic                        fetch_valid,
    output logic [`HMI_DATA_W-1:0]      fetch_data,
    // program write requests
    input  wire logic                   pwr_req,
    input  wire logic [`HMI_PROG_AW-1:0] pwr_addr,
    input  wire logic [`HMI_DATA_W-1:0] pwr_data,
    output logic                        pwr_ack,
    // data read requests
    input  wire logic                   drd_req,
    input  wire logic [`HMI_DAB_W-1:0]  drd_addr,
    input  wire hmi_pkg::hmi_size_t     drd_size,
    output logic                        drd_ack,
    output logic                        drd_valid,
    output logic [`HMI_DATA_W-1:0]      drd_data,
    // data write requests
    input  wire logic                   dwr_req,
    input  wire logic [`HMI_DAB_W-1:0]  dwr_addr,
    input  wire hmi_pkg::hmi_size_t     dwr_size,
    input  wire logic [`HMI_DATA_W-1:0] dwr_data,
    output logic                        dwr_ack,
    // vector fetch flag
    output logic                        vec_hit,
    // memory link
    hmi_bus_if.cpu                      bus
);
    // ==========================================
    // arbitration
    logic grant_pw;
    logic grant_pr;
    logic grant_dw;
    logic grant_dr;
    logic hazard;
    logic pr_q;
    logic dr_q;
    // a data read of a pair being written waits while that write is granted
    assign hazard   = dwr_req && drd_req && (dwr_addr[31:1] == drd_addr[31:1]);
    // program write owns program address and write data buses
    assign grant_pw = pwr_req;
    assign grant_pr = fetch_req && !grant_pw;
    assign grant_dw = dwr_req && !grant_pw;
    assign grant_dr = drd_req && !(hazard && grant_dw);
    assign pwr_ack  = grant_pw;
    assign dwr_ack  = grant_dw;
    assign drd_ack  = grant_dr;
    // ==========================================
    // bus drive, registered so every line is synchronous
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bus.prog_addr_bus <= '0;
            bus.prog_rd       <= 1'b0;
            bus.prog_wr       <= 1'b0;
        end else begin
            // address as generated, odd included
            bus.prog_addr_bus <= grant_pw ? pwr_addr : fetch_addr;
            bus.prog_rd       <= grant_pr;
            bus.prog_wr       <= grant_pw;
        end
    end
    // data read address and type
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bus.data_rd_addr_bus  <= '0;
            bus.data_rd           <= 1'b0;
            bus.data_rd_size      <= hmi_pkg::HMI_SZ_16;
            bus.rd_low_byte_lane  <= 1'b0;
            bus.rd_high_byte_lane <= 1'b0;
        end else begin
            bus.data_rd_addr_bus  <= drd_addr;
            bus.data_rd           <= grant_dr;
            bus.data_rd_size      <= drd_size;
            bus.rd_low_byte_lane  <= grant_dr && drd_size == hmi_pkg::HMI_SZ_LO8;
            bus.rd_high_byte_lane <= grant_dr && drd_size == hmi_pkg::HMI_SZ_HI8;
        end
    end
    // data write address, type and shared write data
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bus.data_wr_addr_bus   <= '0;
            bus.data_wr            <= 1'b0;
            bus.data_wr_size       <= hmi_pkg::HMI_SZ_16;
            bus.shared_wr_data_bus <= '0;
            bus.wr_low_byte_lane   <= 1'b0;
            bus.wr_high_byte_lane  <= 1'b0;
        end else begin
            bus.data_wr_addr_bus   <= dwr_addr;
            bus.data_wr            <= grant_dw;
            bus.data_wr_size       <= grant_pw ? hmi_pkg::HMI_SZ_32 : dwr_size;
            bus.shared_wr_data_bus <= grant_pw ? pwr_data : dwr_data;
            bus.wr_low_byte_lane   <= grant_dw && dwr_size == hmi_pkg::HMI_SZ_LO8;
            bus.wr_high_byte_lane  <= grant_dw && dwr_size == hmi_pkg::HMI_SZ_HI8;
        end
    end
    // ==========================================
    // answers: memory returns data one cycle after the bus cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pr_q        <= 1'b0;
            dr_q        <= 1'b0;
            fetch_valid <= 1'b0;
            drd_valid   <= 1'b0;
            fetch_data  <= '0;
            drd_data    <= '0;
            vec_hit     <= 1'b0;
        end else begin
            pr_q        <= bus.prog_rd;
            dr_q        <= bus.data_rd;
            fetch_valid <= pr_q;
            drd_valid   <= dr_q;
            if (pr_q) begin
                fetch_data <= bus.prog_rd_data_bus;
            end
            if (dr_q) begin
                drd_data <= bus.data_rd_data_bus;
            end
            // vector table occupies top 64 program words
            vec_hit <= grant_pr && fetch_addr >= `HMI_VEC_BASE;
        end
    end
endmodule

/* File: hmi_monitor.sv */
`timescale 1ns/1ps
`include "hmi_params.svh"
module hmi_monitor #(
    parameter int AW = `HMI_MEM_DEPTH_LOG
) (
    // clock and reset
    input wire logic                   clk,
    input wire logic                   rst_b,
    // strobes and sizes
    input wire logic                   prog_rd,
    input wire logic                   prog_wr,
    input wire logic                   data_rd,
    input wire logic                   data_wr,
    input wire hmi_pkg::hmi_size_t     data_rd_size,
    input wire hmi_pkg::hmi_size_t     data_wr_size,
    // addresses and read data
    input wire logic [`HMI_PROG_AW-1:0] prog_addr_bus,
    input wire logic [`HMI_DAB_W-1:0]  data_rd_addr_bus,
    input wire logic [`HMI_DAB_W-1:0]  data_wr_addr_bus,
    input wire logic [`HMI_DATA_W-1:0] prog_rd_data_bus,
    input wire logic [`HMI_DATA_W-1:0] data_rd_data_bus,
    // byte lanes
    input wire logic                   rd_low_byte_lane,
    input wire logic                   rd_high_byte_lane,
    input wire logic                   wr_low_byte_lane,
    input wire logic                   wr_high_byte_lane
);
    // ========
    // bus rules
    default clocking mon_cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    chk_prog_rw_excl: assert property (!(prog_rd && prog_wr))
        else $error("program read and write share a cycle");
    chk_pwr_dwr_excl: assert property (!(prog_wr && data_wr))
        else $error("program and data write share a cycle");
    // reset itself is the cause here, so it cannot disable the check
    chk_idle_reset: assert property (disable iff (1'b0) !rst_b |->
        !(prog_rd || prog_wr || data_rd || data_wr) && prog_addr_bus == '0)
        else $error("bus busy during reset");
    // both spaces decode the same block, after even alignment
    chk_same_decode: assert property (
        prog_rd && data_rd && data_rd_size == hmi_pkg::HMI_SZ_32 &&
        prog_addr_bus[AW-1:1] == data_rd_addr_bus[AW-1:1] |=>
        prog_rd_data_bus == data_rd_data_bus)
        else $error("program and data views differ");
    chk_rd_lanes: assert property (
        rd_low_byte_lane == (data_rd && data_rd_size == hmi_pkg::HMI_SZ_LO8) &&
        rd_high_byte_lane == (data_rd && data_rd_size == hmi_pkg::HMI_SZ_HI8))
        else $error("read byte lane wrong");
    chk_wr_lanes: assert property (
        wr_low_byte_lane == (data_wr && data_wr_size == hmi_pkg::HMI_SZ_LO8) &&
        wr_high_byte_lane == (data_wr && data_wr_size == hmi_pkg::HMI_SZ_HI8))
        else $error("write byte lane wrong");
    chk_pwr_size: assert property (prog_wr |-> data_wr_size == hmi_pkg::HMI_SZ_32)
        else $error("program write size not 32");
    chk_rw_order: assert property (!(data_rd && data_wr &&
        data_rd_addr_bus[31:1] == data_wr_addr_bus[31:1]))
        else $error("read and write of one pair together");
    cov_three_way: cover property (prog_rd && data_rd && data_wr);
    cov_prog_wr: cover property (prog_wr);
    cov_hi_read: cover property (rd_high_byte_lane);
endmodule

/* File: cpu_harvard_memory_interface_tb.sv */
`timescale 1ns/1ps
`include "hmi_params.svh"
module cpu_harvard_memory_interface_tb;
    // ========
    // signals and table
    typedef struct {
        logic [31:0] wa, wd, ra, mask, exp;
        hmi_pkg::hmi_size_t ws, rs;
    } hmi_row_t;
    localparam hmi_pkg::hmi_size_t s32 = hmi_pkg::HMI_SZ_32;
    logic               clk = 1'b0;
    logic               rst_b = 1'b1;
    logic               freq = 1'b0, preq = 1'b0, drq = 1'b0, dwq = 1'b0;
    logic [21:0]        fa = '0, pa = '0;
    logic [31:0]        pd = '0, ra = '0, wa = '0, wd = '0;
    hmi_pkg::hmi_size_t rs = s32, ws = s32;
    logic               fv, pk, rk, rv, wk, vh;
    logic [31:0]        fd, rdat, f_d, r_d;
    logic [2:0]         seen;
    int                 n_errors = 0, n_checks = 0;
    // byte accesses move the whole 16-bit word; the strobes only name the lane
    hmi_row_t rows [5] = '{
        '{32'h20, 32'h1234ABCD, 32'h21, '1, 32'h1234ABCD, s32, s32},
        '{32'h41, 32'hCAFE5678, 32'h40, '1, 32'hCAFE5678, s32, s32},
        '{32'h30, 32'hBEEF, 32'h30, 32'hFFFF, 32'hBEEF, hmi_pkg::HMI_SZ_16, hmi_pkg::HMI_SZ_16},
        '{32'h31, 32'h12A5, 32'h31, 32'hFFFF, 32'h12A5, hmi_pkg::HMI_SZ_LO8, hmi_pkg::HMI_SZ_16},
        '{32'h32, 32'h5A00, 32'h32, '1, 32'h5A00, hmi_pkg::HMI_SZ_HI8, hmi_pkg::HMI_SZ_HI8}};
    hmi_bus_if u_hmi_bus_if ();
    hmi_cpu_end u_hmi_cpu_end (.clk(clk), .rst_b(rst_b), .fetch_req(freq), .fetch_addr(fa),
        .fetch_valid(fv), .fetch_data(fd), .pwr_req(preq), .pwr_addr(pa), .pwr_data(pd),
        .pwr_ack(pk), .drd_req(drq), .drd_addr(ra), .drd_size(rs), .drd_ack(rk),
        .drd_valid(rv), .drd_data(rdat), .dwr_req(dwq), .dwr_addr(wa), .dwr_size(ws),
        .dwr_data(wd), .dwr_ack(wk), .vec_hit(vh), .bus(u_hmi_bus_if.cpu));
    hmi_mem_end #(.AW(10)) u_hmi_mem_end (.clk(clk), .rst_b(rst_b), .bus(u_hmi_bus_if.mem));
    hmi_monitor #(.AW(10)) u_hmi_monitor (.clk(clk), .rst_b(rst_b),
        .prog_rd(u_hmi_bus_if.prog_rd), .prog_wr(u_hmi_bus_if.prog_wr),
        .data_rd(u_hmi_bus_if.data_rd), .data_wr(u_hmi_bus_if.data_wr),
        .data_rd_size(u_hmi_bus_if.data_rd_size), .data_wr_size(u_hmi_bus_if.data_wr_size),
        .prog_addr_bus(u_hmi_bus_if.prog_addr_bus),
        .data_rd_addr_bus(u_hmi_bus_if.data_rd_addr_bus),
        .data_wr_addr_bus(u_hmi_bus_if.data_wr_addr_bus),
        .prog_rd_data_bus(u_hmi_bus_if.prog_rd_data_bus),
        .data_rd_data_bus(u_hmi_bus_if.data_rd_data_bus),
        .rd_low_byte_lane(u_hmi_bus_if.rd_low_byte_lane),
        .rd_high_byte_lane(u_hmi_bus_if.rd_high_byte_lane),
        .wr_low_byte_lane(u_hmi_bus_if.wr_low_byte_lane),
        .wr_high_byte_lane(u_hmi_bus_if.wr_high_byte_lane));
    always #4 clk = ~clk;
    // wide enough for a flag beside a word, or two words side by side
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // bounded wait for one requester's grant; a stuck request ends the run
    task automatic grant(input int k);
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            if (((k == 0) ? (freq && !preq) : (k == 1) ? pk : (k == 2) ? rk : wk) === 1'b1)
                return;
        end
        n_errors++;
        finish_test();
    endtask
    // k: 0 fetch, 1 program write, 2 data read, 3 data write
    task automatic op(input int k, input logic [31:0] a, d, input hmi_pkg::hmi_size_t s);
        @(negedge clk);
        {fa, pa, ra, wa, pd, wd} = {a[21:0], a[21:0], a, a, d, d};
        rs = s;
        ws = s;
        {freq, preq, drq, dwq} = 4'b1000 >> k;
        grant(k);
        @(negedge clk);
        {freq, preq, drq, dwq} = 4'h0;
    endtask
    // gathers answers over a window wider than the fixed latency
    task automatic collect();
        seen = '0;
        repeat (6) begin
            @(posedge clk);
            if (fv === 1'b1)
                {seen[0], f_d} = {1'b1, fd};
            if (rv === 1'b1)
                {seen[1], r_d} = {1'b1, rdat};
            if (vh === 1'b1)
                seen[2] = 1'b1;
        end
    endtask
    // ========
    // main sequence
    initial begin
        // a real falling edge, so every flop with a reset is cleared before the first clock
        #1;
        rst_b = 1'b0;
        repeat (12) @(negedge clk);
        chk({u_hmi_bus_if.prog_rd, u_hmi_bus_if.prog_wr, u_hmi_bus_if.data_rd}, 3'h0);
        chk({fv, rv, vh}, 3'h0);
        rst_b = 1'b1;
        foreach (rows[i]) begin
            op(3, rows[i].wa, rows[i].wd, rows[i].ws);
            op(2, rows[i].ra, 32'h0, rows[i].rs);
            collect();
            chk({seen[1], r_d & rows[i].mask}, {1'b1, rows[i].exp});
        end
        op(1, 32'h80, 32'h55AA33CC, s32);
        op(0, 32'h81, 32'h0, s32);
        collect();
        chk({seen[0], f_d}, {1'b1, 32'h55AA33CC});
        op(0, 32'h3FFFC0, 32'h0, s32);
        collect();
        chk(seen, 3'h5);
        op(0, 32'h3FFFBF, 32'h0, s32);
        collect();
        chk(seen, 3'h1);
        // program write holds off the fetch and data write, then three buses run at once
        @(negedge clk);
        {fa, pa, pd, wa, wd} = {22'h20, 22'h90, 32'h0BADF00D, 32'h70, 32'h600DCAFE};
        {freq, preq, dwq} = 3'b111;
        @(posedge clk);
        chk({pk, wk}, 2'b10);
        @(negedge clk);
        {preq, drq, ra} = {2'b01, 32'h21};
        @(posedge clk);
        chk({rk, wk}, 2'b11);
        @(negedge clk);
        {freq, drq, dwq} = 3'b000;
        collect();
        chk({f_d, r_d}, {2{32'h1234ABCD}});
        op(0, 32'h90, 32'h0, s32);
        collect();
        chk({seen[0], f_d}, {1'b1, 32'h0BADF00D});
        // a read of the pair being written waits and then sees the new value
        @(negedge clk);
        {wa, wd, ra} = {32'h71, 32'hFEEDBEEF, 32'h70};
        {drq, dwq} = 2'b11;
        @(posedge clk);
        chk({rk, wk}, 2'b01);
        @(negedge clk);
        dwq = 1'b0;
        grant(2);
        @(negedge clk);
        drq = 1'b0;
        collect();
        chk({seen[1], r_d}, {1'b1, 32'hFEEDBEEF});
        // reset in mid-run kills a fetch in flight and clears the held answers
        @(negedge clk);
        {fa, freq} = {22'h90, 1'b1};
        @(negedge clk);
        {freq, rst_b} = 2'b00;
        #1;
        chk({fv, rv, vh, u_hmi_bus_if.prog_rd}, 4'h0);
        chk({fd, rdat}, 64'h0);
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        // memory contents survive the reset, so a fresh fetch still finds them
        op(0, 32'h90, 32'h0, s32);
        collect();
        chk({seen[0], f_d}, {1'b1, 32'h0BADF00D});
        finish_test();
    end
endmodule
